/* rtl/exec_unit.sv */
// Purpose: executes a subset of an 8-bit core's instructions
// Assumes: one op per request cycle, memory address supplied with it
// Notes: all outputs registered; data memory is an internal array
`timescale 1ns/1ps
`include "exec_params.svh"

// Summary of operation
// - clear memory writes zero, flags kept
// - clear bit zeroes one bit only
// - watchdog clear zeroes counter, pdf, timeout unless overflow in same cycle
// - preclear pair together clears watchdog counter, pdf, timeout unless overflow in same cycle
// - single preclear only records itself
// - invert memory byte, update zero only
// - invert into accumulator, memory kept
// - low nibble plus six when over nine
// - high nibble adjust sets carry, to memory
// - decrement to memory or accumulator, zero
// - increment to memory or accumulator, zero
// - halt stops execution, pc plus one
// - halt clears watchdog, sets pdf, clears timeout unless overflow in same cycle
// - jump loads pc, flags kept
// - immediate move loads accumulator, flags kept
// - moves copy between accumulator and memory
// - idle only advances pc
// - or variants, zero flag only
// - return pops pc over two cycles
// - return with value loads accumulator too
// - interrupt return sets global interrupt enable
// - rotate left, bit seven to zero
module exec_unit #(
	parameter int ADDR_W = 7,
	parameter int PC_W = 11,
	parameter int STACK_DEPTH = 4,
	parameter int WDT_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// request
	input wire logic op_valid,
	input wire exec_pkg::op_t op,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] imm,
	input wire logic [PC_W-1:0] jump_addr,
	// push for calls and interrupts, from the sequencer
	input wire logic stack_push,
	input wire logic [PC_W-1:0] push_pc,
	// watchdog tick and wake
	input wire logic wdt_tick,
	input wire logic wake,
	// state seen outside
	output logic busy_q,
	output logic halted_q,
	output logic [7:0] acc_q,
	output logic [PC_W-1:0] pc_q,
	output exec_pkg::flags_t flags_q,
	output logic global_interrupt_enable_q,
	output logic [WDT_W-1:0] watchdog_counter_q,
	output logic [7:0] mem_rdata_q
);

	// the stack pointer wraps, so the depth must be a power of two
	if (ADDR_W < 1 || ADDR_W > 10 || PC_W < 2 || STACK_DEPTH < 1 || WDT_W < 1 ||
		(STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_params
		$error("exec_unit: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////
	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
	logic [7:0] mem_q [0:(1<<ADDR_W)-1];
	logic [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
	logic [SP_W-1:0] sp_q;
	exec_pkg::state_t state_q;
	logic pre1_seen_q, pre2_seen_q;
	logic [PC_W-1:0] ret_pc_q;

	logic take;
	logic [7:0] m;
	logic [SP_W-1:0] sp_top;
	logic [4:0] lo_sum, hi_sum;
	logic lo_adj, nibble_adjust_carry, hi_adj;
	logic [3:0] lo_res, hi_res;
	logic pair_done;
	logic wdt_overflow;
	logic overflow_q, zero_q, half_carry_flag_q, carry_q;
	logic watchdog_timeout_flag_q, power_down_flag_q;

	assign take = op_valid && (state_q == exec_pkg::st_ready);
	assign m = mem_q[mem_addr];
	assign sp_top = sp_q - SP_W'(1);
	assign wdt_overflow = wdt_tick && (&watchdog_counter_q);
	// flags are kept per concern and gathered here, still straight from flops
	assign flags_q = {watchdog_timeout_flag_q, power_down_flag_q, overflow_q, zero_q,
		half_carry_flag_q, carry_q};

	// decimal adjust: low nibble then high nibble with internal carry
	always_comb begin
		lo_sum = {1'b0, acc_q[3:0]};
		lo_adj = (lo_sum > `EXEC_BCD_MAX) || flags_q.half_carry_flag;
		lo_res = lo_adj ? 4'(acc_q[3:0] + `EXEC_BCD_ADJ) : acc_q[3:0];
		// an incoming half carry means the low nibble cannot carry a second time
		nibble_adjust_carry = lo_adj && !flags_q.half_carry_flag;
		hi_sum = {1'b0, acc_q[7:4]} + {4'h0, nibble_adjust_carry};
		hi_adj = (hi_sum > `EXEC_BCD_MAX) || flags_q.carry;
		hi_res = hi_adj ? 4'(hi_sum + 5'h06) : hi_sum[3:0];
	end

	// a preclear completes when the other one has already been seen
	assign pair_done = take && ((op == exec_pkg::op_wdt_pre1 && pre2_seen_q) ||
		(op == exec_pkg::op_wdt_pre2 && pre1_seen_q));

	////////////////////////////////////////////////////////////////////////
	// sequencing: return takes a second cycle, halt waits for wake
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= exec_pkg::st_ready;
			busy_q <= 1'b0;
			halted_q <= 1'b0;
		end else begin
			case (state_q)
				exec_pkg::st_ready: begin
					if (take && (op == exec_pkg::op_ret || op == exec_pkg::op_ret_imm ||
						op == exec_pkg::op_interrupt_return_op)) begin
						state_q <= exec_pkg::st_ret_wait;
						busy_q <= 1'b1;
					end else if (take && op == exec_pkg::op_halt) begin
						state_q <= exec_pkg::st_halted;
						busy_q <= 1'b1;
						halted_q <= 1'b1;
					end
				end
				exec_pkg::st_ret_wait: begin
					state_q <= exec_pkg::st_ready;
					busy_q <= 1'b0;
				end
				exec_pkg::st_halted: begin
					if (wake) begin
						state_q <= exec_pkg::st_ready;
						busy_q <= 1'b0;
						halted_q <= 1'b0;
					end
				end
				default: state_q <= exec_pkg::st_ready;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data memory writes
	always_ff @(posedge clk) begin
		if (take) begin
			case (op)
				exec_pkg::op_clear_mem: mem_q[mem_addr] <= `EXEC_ZERO_BYTE;
				exec_pkg::op_clear_bit: mem_q[mem_addr][bit_sel] <= 1'b0;
				exec_pkg::op_invert_mem: mem_q[mem_addr] <= ~m;
				exec_pkg::op_decimal_adjust: mem_q[mem_addr] <= {hi_res, lo_res};
				exec_pkg::op_dec_mem: mem_q[mem_addr] <= m - 8'h01;
				exec_pkg::op_inc_mem: mem_q[mem_addr] <= m + 8'h01;
				exec_pkg::op_mov_to_mem: mem_q[mem_addr] <= acc_q;
				exec_pkg::op_or_mem: mem_q[mem_addr] <= acc_q | m;
				exec_pkg::op_rotate_left: mem_q[mem_addr] <= {m[6:0], m[7]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			mem_rdata_q <= `EXEC_ZERO_BYTE;
		else
			mem_rdata_q <= m;
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			acc_q <= `EXEC_ACC_RST;
		end else if (take) begin
			case (op)
				exec_pkg::op_invert_acc: acc_q <= ~m;
				exec_pkg::op_dec_acc: acc_q <= m - 8'h01;
				exec_pkg::op_inc_acc: acc_q <= m + 8'h01;
				exec_pkg::op_mov_imm: acc_q <= imm;
				exec_pkg::op_mov_to_acc: acc_q <= m;
				exec_pkg::op_or_acc: acc_q <= acc_q | m;
				exec_pkg::op_or_imm: acc_q <= acc_q | imm;
				exec_pkg::op_ret_imm: acc_q <= imm;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arithmetic flags; watchdog-related flags live with the watchdog
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			overflow_q <= 1'b0;
			zero_q <= 1'b0;
			half_carry_flag_q <= 1'b0;
			carry_q <= 1'b0;
		end else if (take) begin
			case (op)
				exec_pkg::op_invert_mem, exec_pkg::op_invert_acc:
					zero_q <= (~m == 8'h00);
				exec_pkg::op_dec_mem, exec_pkg::op_dec_acc:
					zero_q <= (m == 8'h01);
				exec_pkg::op_inc_mem, exec_pkg::op_inc_acc:
					zero_q <= (m == 8'hff);
				exec_pkg::op_or_acc, exec_pkg::op_or_mem:
					zero_q <= ((acc_q | m) == 8'h00);
				exec_pkg::op_or_imm:
					zero_q <= ((acc_q | imm) == 8'h00);
				exec_pkg::op_decimal_adjust:
					if (hi_adj) carry_q <= 1'b1;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog, preclear pair, power-down and time-out flags
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			watchdog_counter_q <= '0;
			watchdog_timeout_flag_q <= 1'b0;
			power_down_flag_q <= 1'b0;
		end else if (take && (op == exec_pkg::op_wdt_clear || pair_done)) begin
			watchdog_counter_q <= '0;
			// an overflow in the same cycle still marks time-out
			watchdog_timeout_flag_q <= wdt_overflow;
			power_down_flag_q <= 1'b0;
		end else if (take && op == exec_pkg::op_halt) begin
			watchdog_counter_q <= '0;
			power_down_flag_q <= 1'b1;
			watchdog_timeout_flag_q <= wdt_overflow;
		end else if (wdt_tick) begin
			// overflow marks time-out; counter wraps
			watchdog_counter_q <= watchdog_counter_q + WDT_W'(1);
			if (wdt_overflow)
				watchdog_timeout_flag_q <= 1'b1;
		end
	end

	// a lone preclear only records itself and never costs a tick
	always_ff @(posedge clk) begin
		if (!rst_b || (take && (op == exec_pkg::op_wdt_clear || pair_done))) begin
			pre1_seen_q <= 1'b0;
			pre2_seen_q <= 1'b0;
		end else if (take && op == exec_pkg::op_wdt_pre1) begin
			pre1_seen_q <= 1'b1;
		end else if (take && op == exec_pkg::op_wdt_pre2) begin
			pre2_seen_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter, stack and interrupt enable
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pc_q <= `EXEC_PC_RST;
			sp_q <= '0;
			ret_pc_q <= '0;
			global_interrupt_enable_q <= 1'b0;
		end else if (state_q == exec_pkg::st_ret_wait) begin
			pc_q <= ret_pc_q;
		end else if (take) begin
			case (op)
				exec_pkg::op_jump: pc_q <= jump_addr;
				exec_pkg::op_ret, exec_pkg::op_ret_imm, exec_pkg::op_interrupt_return_op: begin
					ret_pc_q <= stack_q[sp_top];
					sp_q <= sp_top;
					if (op == exec_pkg::op_interrupt_return_op)
						global_interrupt_enable_q <= 1'b1;
				end
				default: pc_q <= pc_q + PC_W'(1);
			endcase
		end else if (stack_push) begin
			sp_q <= sp_q + SP_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (stack_push && !take)
			stack_q[sp_q] <= push_pc;
	end

	////////////////////////////////////////////////////////////////////////
	a_clear_zero: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_clear_mem ##1 mem_addr == $past(mem_addr) |=>
		mem_rdata_q == 8'h00)
		else $error("clear memory wrong");
	a_halt_flags: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_halt |=> flags_q.power_down_flag &&
		flags_q.watchdog_timeout_flag == $past(wdt_overflow) &&
		watchdog_counter_q == '0 && halted_q)
		else $error("halt flags wrong");
	a_wdt_clear: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_wdt_clear |=> watchdog_counter_q == '0 &&
		!flags_q.power_down_flag && flags_q.watchdog_timeout_flag == $past(wdt_overflow))
		else $error("watchdog clear wrong");
	a_pre_single: assert property (@(posedge clk) disable iff (!rst_b)
		take && !pair_done && !wdt_tick &&
		(op == exec_pkg::op_wdt_pre1 || op == exec_pkg::op_wdt_pre2) |=>
		$stable(flags_q[5:4]) && $stable(watchdog_counter_q))
		else $error("single preclear changed state");
	a_pre_pair: assert property (@(posedge clk) disable iff (!rst_b)
		pair_done |=> watchdog_counter_q == '0 && !flags_q.power_down_flag)
		else $error("preclear pair did not clear");
	a_jump_pc: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_jump |=> pc_q == $past(jump_addr) &&
		$stable(flags_q[3:0]))
		else $error("jump wrong");
	a_idle_pc: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_idle |=> pc_q == $past(pc_q) + PC_W'(1) &&
		$stable(acc_q))
		else $error("idle changed state");
	a_ret_two: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_ret |=> busy_q ##1 !busy_q)
		else $error("return not two cycles");
	a_interrupt_return_op_gie: assert property (@(posedge clk) disable iff (!rst_b)
		take && op == exec_pkg::op_interrupt_return_op |=> global_interrupt_enable_q)
		else $error("interrupt enable not set");
	a_imm_acc: assert property (@(posedge clk) disable iff (!rst_b)
		take && (op == exec_pkg::op_mov_imm || op == exec_pkg::op_ret_imm)
		|=> acc_q == $past(imm) && $stable(flags_q.zero))
		else $error("immediate load wrong");
	c_halt: cover property (@(posedge clk) take && op == exec_pkg::op_halt);
	c_pair: cover property (@(posedge clk) pair_done);
	c_ret: cover property (@(posedge clk) take && op == exec_pkg::op_ret_imm);
	c_daa: cover property (@(posedge clk) take && op == exec_pkg::op_decimal_adjust && hi_adj);
endmodule

/* shared/exec_params.svh */
// Purpose: constants for the instruction execution unit
// Assumes: 8-bit data path, small stack
// Notes: definitions only
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define EXEC_BCD_ADJ 4'h6
`define EXEC_BCD_MAX 5'h09
`define EXEC_ZERO_BYTE 8'h00
`define EXEC_ACC_RST 8'h00
`define EXEC_PC_RST 11'h000
`define EXEC_RET_CYCLES 2
`endif

/* shared/exec_pkg.sv */
// Purpose: types for the instruction execution unit
// Assumes: one operation issued per request
// Notes: flags travel as one packed struct
package exec_pkg;
	typedef enum logic [4:0] {
		op_idle, op_clear_mem, op_clear_bit, op_wdt_clear, op_wdt_pre1, op_wdt_pre2,
		op_invert_mem, op_invert_acc, op_decimal_adjust, op_dec_mem, op_dec_acc,
		op_inc_mem, op_inc_acc, op_halt, op_jump, op_mov_imm, op_mov_to_mem,
		op_mov_to_acc, op_or_acc, op_or_imm, op_or_mem, op_ret, op_ret_imm,
		op_interrupt_return_op, op_rotate_left
	} op_t;
	typedef struct packed {
		logic watchdog_timeout_flag;
		logic power_down_flag;
		logic overflow;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} flags_t;
	typedef enum {st_ready, st_ret_wait, st_halted} state_t;
endpackage

/* tb/exec_unit_tb.sv */
// Purpose: self-checking bench for exec_unit
// Assumes: default parameters, one request every second cycle
// Notes: memory is loaded through moves, never read before written
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module exec_unit_tb;
	logic clk;
	logic rst_b;
	logic op_valid;
	logic stack_push;
	logic wdt_tick;
	logic wake;
	exec_pkg::op_t op;
	logic [6:0] mem_addr;
	logic [2:0] bit_sel;
	logic [7:0] imm;
	logic [7:0] rd;
	logic [10:0] jump_addr;
	logic [10:0] push_pc;
	logic busy_q;
	logic halted_q;
	logic [7:0] acc_q;
	logic [10:0] pc_q;
	exec_pkg::flags_t flags_q;
	exec_pkg::flags_t fl;
	logic global_interrupt_enable_q;
	logic [7:0] watchdog_counter_q;
	logic [7:0] mem_rdata_q;
	int miscompares = 0;
	int n_tests = 0;

	exec_unit u_exec_unit (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op(op),
		.mem_addr(mem_addr), .bit_sel(bit_sel), .imm(imm), .jump_addr(jump_addr),
		.stack_push(stack_push), .push_pc(push_pc), .wdt_tick(wdt_tick), .wake(wake),
		.busy_q(busy_q), .halted_q(halted_q), .acc_q(acc_q), .pc_q(pc_q), .flags_q(flags_q),
		.global_interrupt_enable_q(global_interrupt_enable_q),
		.watchdog_counter_q(watchdog_counter_q), .mem_rdata_q(mem_rdata_q));

	////////////////////////////////////////////////////////////////////////////////
	// an idle cycle follows every request so op_valid is never driven twice at once
	task automatic issue(input exec_pkg::op_t o, input logic [6:0] a, input logic [7:0] x);
		@(negedge clk);
		op = o;
		mem_addr = a;
		imm = x;
		op_valid = 1'b1;
		@(negedge clk);
		op_valid = 1'b0;
	endtask
	task automatic peek(input logic [6:0] a);
		@(negedge clk);
		mem_addr = a;
		@(negedge clk);
		rd = mem_rdata_q;
	endtask
	task automatic ticks(input int n);
		@(negedge clk);
		wdt_tick = 1'b1;
		repeat (n) @(negedge clk);
		wdt_tick = 1'b0;
	endtask
	task automatic push(input logic [10:0] p);
		@(negedge clk);
		push_pc = p;
		stack_push = 1'b1;
		@(negedge clk);
		stack_push = 1'b0;
	endtask
	task automatic leave_halt;
		wake = 1'b1;
		for (int i = 0; i < 20 && halted_q !== 1'b0; i++) @(negedge clk);
		wake = 1'b0;
		`CHK("halted", 1'b0, halted_q)
	endtask
	task automatic finish_test;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_data;
		issue(exec_pkg::op_mov_imm, 7'h03, 8'h5a);
		`CHK("acc", 8'h5a, acc_q)
		fl = flags_q;
		issue(exec_pkg::op_mov_to_mem, 7'h03, 8'h00);
		peek(7'h03);
		`CHK("mem", 8'h5a, rd)
		bit_sel = 3'h4;
		issue(exec_pkg::op_clear_bit, 7'h03, 8'h00);
		peek(7'h03);
		`CHK("mem", 8'h4a, rd)
		issue(exec_pkg::op_rotate_left, 7'h03, 8'h00);
		peek(7'h03);
		`CHK("mem", 8'h94, rd)
		issue(exec_pkg::op_invert_mem, 7'h03, 8'h00);
		peek(7'h03);
		`CHK("mem", 8'h6b, rd)
		issue(exec_pkg::op_invert_acc, 7'h03, 8'h00);
		`CHK("acc", 8'h94, acc_q)
		peek(7'h03);
		`CHK("mem", 8'h6b, rd)
		issue(exec_pkg::op_clear_mem, 7'h03, 8'h00);
		peek(7'h03);
		`CHK("mem", 8'h00, rd)
		`CHK("flags", fl, flags_q)
		issue(exec_pkg::op_dec_acc, 7'h03, 8'h00);
		`CHK("acc", 8'hff, acc_q)
		issue(exec_pkg::op_inc_mem, 7'h03, 8'h00);
		`CHK("zero", 1'b0, flags_q.zero)
		issue(exec_pkg::op_dec_mem, 7'h03, 8'h00);
		`CHK("zero", 1'b1, flags_q.zero)
		peek(7'h03);
		`CHK("mem", 8'h00, rd)
		issue(exec_pkg::op_inc_acc, 7'h03, 8'h00);
		`CHK("acc", 8'h01, acc_q)
		issue(exec_pkg::op_invert_mem, 7'h03, 8'h00);
		issue(exec_pkg::op_invert_acc, 7'h03, 8'h00);
		`CHK("zero", 1'b1, flags_q.zero)
		issue(exec_pkg::op_mov_to_acc, 7'h03, 8'h00);
		`CHK("acc", 8'hff, acc_q)
		`CHK("zero", 1'b1, flags_q.zero)
	endtask

	task automatic t_or;
		issue(exec_pkg::op_mov_imm, 7'h05, 8'h21);
		issue(exec_pkg::op_mov_to_mem, 7'h05, 8'h00);
		issue(exec_pkg::op_or_imm, 7'h05, 8'h00);
		`CHK("zero", 1'b0, flags_q.zero)
		issue(exec_pkg::op_mov_imm, 7'h05, 8'h00);
		issue(exec_pkg::op_or_imm, 7'h05, 8'h00);
		`CHK("zero", 1'b1, flags_q.zero)
		issue(exec_pkg::op_mov_imm, 7'h05, 8'h0c);
		issue(exec_pkg::op_or_mem, 7'h05, 8'h00);
		`CHK("acc", 8'h0c, acc_q)
		peek(7'h05);
		`CHK("mem", 8'h2d, rd)
		issue(exec_pkg::op_mov_imm, 7'h05, 8'h50);
		issue(exec_pkg::op_or_acc, 7'h05, 8'h00);
		`CHK("acc", 8'h7d, acc_q)
	endtask

	task automatic t_daa;
		logic [7:0] av [4] = '{8'h15, 8'h0a, 8'h9a, 8'h12};
		logic [7:0] ev [4] = '{8'h15, 8'h10, 8'h00, 8'h72};
		logic cv [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 4; i++) begin
			issue(exec_pkg::op_mov_imm, 7'h06, av[i]);
			fl = flags_q;
			issue(exec_pkg::op_decimal_adjust, 7'h06, 8'h00);
			`CHK("carry", cv[i], flags_q.carry)
			`CHK("zero", fl.zero, flags_q.zero)
			peek(7'h06);
			`CHK("daa", ev[i], rd)
		end
	endtask

	task automatic t_wdt;
		// 256 ticks wrap the counter and raise the time-out flag
		ticks(256);
		`CHK("to", 1'b1, flags_q.watchdog_timeout_flag)
		issue(exec_pkg::op_wdt_pre2, 7'h00, 8'h00);
		`CHK("to", 1'b1, flags_q.watchdog_timeout_flag)
		ticks(2);
		fl = flags_q;
		jump_addr = pc_q;
		issue(exec_pkg::op_halt, 7'h00, 8'h00);
		`CHK("halted", 1'b1, halted_q)
		`CHK("pc", jump_addr + 11'h001, pc_q)
		`CHK("pdf", 1'b1, flags_q.power_down_flag)
		`CHK("to", 1'b0, flags_q.watchdog_timeout_flag)
		`CHK("wdt", 8'h00, watchdog_counter_q)
		`CHK("c", fl.carry, flags_q.carry)
		issue(exec_pkg::op_mov_imm, 7'h00, 8'h33);
		`CHK("acc", 8'h12, acc_q)
		leave_halt();
		// the lone preclear above is still recorded, so this one completes the pair
		ticks(3);
		issue(exec_pkg::op_wdt_pre1, 7'h00, 8'h00);
		`CHK("wdt", 8'h00, watchdog_counter_q)
		`CHK("pdf", 1'b0, flags_q.power_down_flag)
		issue(exec_pkg::op_halt, 7'h00, 8'h00);
		leave_halt();
		ticks(3);
		issue(exec_pkg::op_wdt_pre2, 7'h00, 8'h00);
		`CHK("wdt", 8'h03, watchdog_counter_q)
		`CHK("pdf", 1'b1, flags_q.power_down_flag)
		issue(exec_pkg::op_wdt_pre1, 7'h00, 8'h00);
		`CHK("wdt", 8'h00, watchdog_counter_q)
		`CHK("pdf", 1'b0, flags_q.power_down_flag)
		issue(exec_pkg::op_halt, 7'h00, 8'h00);
		leave_halt();
		ticks(2);
		issue(exec_pkg::op_wdt_clear, 7'h00, 8'h00);
		`CHK("wdt", 8'h00, watchdog_counter_q)
		`CHK("pdf", 1'b0, flags_q.power_down_flag)
	endtask

	task automatic t_flow;
		fl = flags_q;
		jump_addr = 11'h123;
		issue(exec_pkg::op_jump, 7'h00, 8'h00);
		`CHK("pc", 11'h123, pc_q)
		issue(exec_pkg::op_idle, 7'h00, 8'h00);
		`CHK("pc", 11'h124, pc_q)
		`CHK("flags", fl, flags_q)
		push(11'h055);
		issue(exec_pkg::op_ret, 7'h00, 8'h00);
		`CHK("busy", 1'b1, busy_q)
		@(negedge clk);
		`CHK("pc", 11'h055, pc_q)
		`CHK("busy", 1'b0, busy_q)
		push(11'h066);
		issue(exec_pkg::op_ret_imm, 7'h00, 8'h3c);
		`CHK("acc", 8'h3c, acc_q)
		@(negedge clk);
		`CHK("pc", 11'h066, pc_q)
		push(11'h077);
		issue(exec_pkg::op_interrupt_return_op, 7'h00, 8'h00);
		@(negedge clk);
		`CHK("gie", 1'b1, global_interrupt_enable_q)
		`CHK("pc", 11'h077, pc_q)
		`CHK("flags", fl, flags_q)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
	initial begin
		{rst_b, op_valid, stack_push, wdt_tick, wake} = '0;
		op = exec_pkg::op_idle;
		{mem_addr, bit_sel, imm, jump_addr, push_pc} = '0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		`CHK("acc", 8'h00, acc_q)
		`CHK("pc", 11'h000, pc_q)
		t_data();
		t_or();
		t_daa();
		t_wdt();
		t_flow();
		finish_test();
	end
endmodule
